// File: logic/host_port_params.svh
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// Register byte offsets
`define OFF_CTRL    8'h00
`define OFF_STAT    8'h04
`define OFF_TXLO    8'h08
`define OFF_TXHI    8'h0c
`define OFF_RXLO    8'h10
`define OFF_RXHI    8'h14
`define OFF_CVEC    8'h18

// Control register fields
`define CTRL_FLAG_LSB  0
`define CTRL_HOST_CMD_IRQ_ENABLE      11
`define CTRL_TO_HOST_NOT_FULL_IRQ_ENABLE     12
`define CTRL_TO_HOST_EMPTY_IRQ_ENABLE     13
`define CTRL_FROM_HOST_FULL_IRQ_ENABLE     14
`define CTRL_FROM_HOST_NOT_EMPTY_IRQ_ENABLE     15
`define CTRL_RESET     16'h0000

// Status register fields
`define STAT_RXNE      0
`define STAT_RXFF      1
`define STAT_TXE       2
`define STAT_TXNF      3
`define STAT_FLAG_LSB  4

// Command vector register fields
`define CVEC_CMDP      8
`define CVEC_NMIP      9

// Interrupt vector offsets from the vector base
`define VEC_RX_FULL    12'h940
`define VEC_RX_NE      12'h980
`define VEC_TX_EMPTY   12'h9c0
`define VEC_TX_NF      12'ha00
`define VEC_HOST_CMD   12'ha40
`define VEC_HOST_NMI   12'he00

// FIFO depth in 64-bit entries
`define FIFO_DEPTH     4

`endif

// File: logic/host_port_pkg.sv
package host_port_pkg;
   typedef logic [63:0] entry_t;
   typedef logic [6:0]  cmd_vec_t;
   typedef enum logic [1:0] {
      HT_IDLE   = 2'b00,
      HT_BUSY   = 2'b01,
      HT_NONSEQ = 2'b10,
      HT_SEQ    = 2'b11
   } htrans_e;
endpackage

// File: logic/host_port_handshake_status.sv
`timescale 1ns/10ps
`include "host_port_params.svh"

// Three-stage pin synchroniser, a bit changes once stages two and three agree
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // Synchroniser chain
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Agreement filter, holds old level while stages differ
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level <= '0;
      end else begin
         level <= (s2_q & s3_q) | (level & (s2_q | s3_q));
      end
   end
endmodule // pin_sync

// Simple counted FIFO; push when full and pop when empty are ignored
module fifo_mem #(
   parameter int W     = 64,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       push,
   input  wire logic [W-1:0]               din,
   input  wire logic                       pop,
   output logic      [W-1:0]               dout,
   output logic                            empty,
   output logic                            full
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic          do_push;
   logic          do_pop;

   assign empty   = (cnt_q == '0);
   assign full    = (cnt_q == DEPTH_C);
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;
   assign dout    = mem[rp_q];

   // Storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wp_q] <= din;
      end
   end

   // Pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wp_q <= (wp_q == LAST_C) ? '0 : wp_q + 1'b1;
         end
         if (do_pop) begin
            rp_q <= (rp_q == LAST_C) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
      end
   end
endmodule // fifo_mem

// Operation
// - to-host empty flag set when FIFO empty
// - to-host not-full flag clear when FIFO full
// - from-host full flag set when FIFO full
// - from-host not-empty flag set when data present
// - host tx-empty flag set when words empty
// - host rx-full flag set when words valid
// - core flags mirrored to host status
// - host flags mirrored to core status
// - transmit ready when tx words and FIFO empty
// - maskable request raised only when status and enable
// - command, not-full, empty each own enable
// - receive full, not-empty each own enable
// - host non-maskable request has no enable
// - receive full 0x940, not-empty 0x980 lines
// - transmit empty 0x9c0, not-full 0xa00 lines
// - host command 0xa40, nmi 0xe00 lines
// - data irqs clear by FIFO access; vector read
// - move tx words only while FIFO not full
// - load rx words only when host read them
module host_port_handshake_status #(
   parameter int DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rstn,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic      [31:0]              hrdata,
   // Host pins
   input  wire logic                     host_tx_wr,
   input  wire host_port_pkg::entry_t    host_tx_data,
   input  wire logic                     host_rx_rd,
   output host_port_pkg::entry_t         host_rx_data,
   input  wire logic [3:0]               host_to_core_flags,
   input  wire logic                     host_cmd_req,
   input  wire host_port_pkg::cmd_vec_t  host_cmd_vec,
   input  wire logic                     host_nmi_req,
   output logic                          host_tx_empty_flag,
   output logic                          host_rx_full_flag,
   output logic                          transmit_ready_flag,
   output logic      [3:0]               core_to_host_flags,
   // Requests toward the core interrupt controller
   output logic                          irq_rx_full,
   output logic                          irq_rx_not_empty,
   output logic                          irq_tx_empty,
   output logic                          irq_tx_not_full,
   output logic                          irq_host_cmd,
   output logic                          nmi_host
);
   import host_port_pkg::*;

   // Host strobes and flags after synchronisation
   logic [3:0]  strb_lvl;
   logic [3:0]  strb_prev_q;
   logic [3:0]  strb_rise;
   logic [3:0]  hflag_lvl;
   // Bus decode
   logic        ap_take;
   logic        dp_wr_q;
   logic [7:0]  dp_addr_q;
   logic        rd_take;
   logic [31:0] rdata_d;
   logic [31:0] hrdata_q;
   // Registers and holding words
   logic [15:0] ctrl_q;
   logic [31:0] txlo_q;
   entry_t      tx_hold_q;
   logic        tx_full_q;
   entry_t      rx_hold_q;
   logic        rx_valid_q;
   cmd_vec_t    cvec_q;
   logic        cmd_pend_q;
   logic        nmi_pend_q;
   // FIFO handshakes
   logic        thf_push;
   logic        thf_pop;
   entry_t      thf_dout;
   logic        thf_empty;
   logic        thf_full;
   logic        fhf_push;
   logic        fhf_pop;
   entry_t      fhf_dout;
   logic        fhf_empty;
   logic        fhf_full;
   logic [7:0]  stat;
   logic        cvec_rd;

   pin_sync #(.W(4)) u_strb_sync (
      .clk   (clk),
      .rstn  (rstn),
      .pin   ({host_nmi_req, host_cmd_req, host_rx_rd, host_tx_wr}),
      .level (strb_lvl)
   );

   pin_sync #(.W(4)) u_flag_sync (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (host_to_core_flags),
      .level (hflag_lvl)
   );

   // Host events count on the rising edge of the filtered level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strb_prev_q <= '0;
      end else begin
         strb_prev_q <= strb_lvl;
      end
   end
   assign strb_rise = strb_lvl & ~strb_prev_q;

   // Zero-wait slave, so hreadyout always high and response always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign ap_take   = hsel & hready & htrans[1];
   assign rd_take   = ap_take & ~hwrite;
   assign cvec_rd   = rd_take & (haddr[7:0] == `OFF_CVEC);

   // Data phase bookkeeping for writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 8'h00;
      end else begin
         dp_wr_q   <= ap_take & hwrite;
         dp_addr_q <= haddr[7:0];
      end
   end

   // Core status word
   assign stat = {hflag_lvl,
                  ~thf_full,
                  thf_empty,
                  fhf_full,
                  ~fhf_empty};

   // Read mux evaluated in the address phase; unmapped reads give zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (haddr[7:0])
         `OFF_CTRL: rdata_d = {16'h0000, ctrl_q};
         `OFF_STAT: rdata_d = {24'h00_0000, stat};
         `OFF_TXLO: rdata_d = txlo_q;
         `OFF_RXLO: rdata_d = fhf_dout[31:0];
         `OFF_RXHI: rdata_d = fhf_dout[63:32];
         `OFF_CVEC: rdata_d = {22'h00_0000, nmi_pend_q, cmd_pend_q,
                               1'b0, cvec_q};
         default:   rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data held until the next read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata_q <= rdata_d;
      end
   end

   // Control and transmit low word written in the data phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `CTRL_RESET;
         txlo_q <= 32'h0000_0000;
      end else if (dp_wr_q) begin
         if (dp_addr_q == `OFF_CTRL) begin
            ctrl_q <= hwdata[15:0];
         end
         if (dp_addr_q == `OFF_TXLO) begin
            txlo_q <= hwdata;
         end
      end
   end

   // Writing the high word pushes the pair; a push into a full FIFO is lost
   assign thf_push = dp_wr_q & (dp_addr_q == `OFF_TXHI);
   assign thf_pop  = ~rx_valid_q & ~thf_empty;

   fifo_mem #(.W(64), .DEPTH(DEPTH)) u_to_host_fifo (
      .clk   (clk),
      .rstn  (rstn),
      .push  (thf_push),
      .din   ({hwdata, txlo_q}),
      .pop   (thf_pop),
      .dout  (thf_dout),
      .empty (thf_empty),
      .full  (thf_full)
   );

   // Reading the high word pops the entry, low word first by convention
   assign fhf_pop  = rd_take & (haddr[7:0] == `OFF_RXHI);
   assign fhf_push = tx_full_q & ~fhf_full;

   fifo_mem #(.W(64), .DEPTH(DEPTH)) u_from_host_fifo (
      .clk   (clk),
      .rstn  (rstn),
      .push  (fhf_push),
      .din   (tx_hold_q),
      .pop   (fhf_pop),
      .dout  (fhf_dout),
      .empty (fhf_empty),
      .full  (fhf_full)
   );

   // Host transmit words; a host write while still full is dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_hold_q <= '0;
         tx_full_q <= 1'b0;
      end else if (fhf_push) begin
         tx_full_q <= 1'b0;
      end else if (strb_rise[0] && !tx_full_q) begin
         tx_hold_q <= host_tx_data;
         tx_full_q <= 1'b1;
      end
   end

   // Host receive words, refilled only once the host has read them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_hold_q  <= '0;
         rx_valid_q <= 1'b0;
      end else if (thf_pop) begin
         rx_hold_q  <= thf_dout;
         rx_valid_q <= 1'b1;
      end else if (strb_rise[1]) begin
         rx_valid_q <= 1'b0;
      end
   end
   assign host_rx_data = rx_hold_q;

   // Pending command and nmi; a new request wins over a vector read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cvec_q     <= '0;
         cmd_pend_q <= 1'b0;
         nmi_pend_q <= 1'b0;
      end else begin
         if (strb_rise[2]) begin
            cvec_q <= host_cmd_vec;
         end
         cmd_pend_q <= strb_rise[2] | (cmd_pend_q & ~cvec_rd);
         nmi_pend_q <= strb_rise[3] | (nmi_pend_q & ~cvec_rd);
      end
   end

   // Host-visible status, registered for clean pin timing
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_tx_empty_flag  <= 1'b1;
         host_rx_full_flag   <= 1'b0;
         transmit_ready_flag <= 1'b1;
         core_to_host_flags  <= 4'h0;
      end else begin
         host_tx_empty_flag  <= ~tx_full_q;
         host_rx_full_flag   <= rx_valid_q;
         transmit_ready_flag <= ~tx_full_q & fhf_empty;
         core_to_host_flags  <= ctrl_q[`CTRL_FLAG_LSB +: 4];
      end
   end

   // Requests: each level source but the nmi gated by its own enable, one clock late
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_rx_full      <= 1'b0;
         irq_rx_not_empty <= 1'b0;
         irq_tx_empty     <= 1'b0;
         irq_tx_not_full  <= 1'b0;
         irq_host_cmd     <= 1'b0;
         nmi_host         <= 1'b0;
      end else begin
         irq_rx_full      <= fhf_full & ctrl_q[`CTRL_FROM_HOST_FULL_IRQ_ENABLE];
         irq_rx_not_empty <= ~fhf_empty & ctrl_q[`CTRL_FROM_HOST_NOT_EMPTY_IRQ_ENABLE];
         irq_tx_empty     <= thf_empty & ctrl_q[`CTRL_TO_HOST_EMPTY_IRQ_ENABLE];
         irq_tx_not_full  <= ~thf_full & ctrl_q[`CTRL_TO_HOST_NOT_FULL_IRQ_ENABLE];
         irq_host_cmd     <= cmd_pend_q & ctrl_q[`CTRL_HOST_CMD_IRQ_ENABLE];
         nmi_host         <= nmi_pend_q;
      end
   end
   // Lines map to vectors VEC_RX_FULL, VEC_RX_NE, VEC_TX_EMPTY, VEC_TX_NF,
   // VEC_HOST_CMD and VEC_HOST_NMI, in port order
endmodule // host_port_handshake_status

// File: bench/host_port_chk.sv
`timescale 1ns/10ps
// Port-level checks on control, flags and requests
module host_port_chk (
   // Clock, reset and bus
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   // Host side and requests
   input wire logic        host_nmi_req,
   input wire logic        host_tx_empty_flag,
   input wire logic        transmit_ready_flag,
   input wire logic [3:0]  core_to_host_flags,
   input wire logic        irq_rx_full,
   input wire logic        irq_rx_not_empty,
   input wire logic        irq_tx_empty,
   input wire logic        irq_tx_not_full,
   input wire logic        irq_host_cmd,
   input wire logic        nmi_host
);
   logic        wr_q;
   logic [15:0] ctrl_q;
   wire take = hsel && hready && htrans[1];
   wire rd_vec = take && !hwrite && haddr[7:0] == 8'h18;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Shadow control word, written in the data phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q   <= 1'b0;
         ctrl_q <= 16'h0000;
      end else begin
         if (wr_q)
            ctrl_q <= hwdata[15:0];
         wr_q <= take && hwrite && haddr[7:0] == 8'h00;
      end
   end
   // Request lines lag the enable by one register
   property masked(logic r, logic e);
      r |-> $past(e);
   endproperty
   a_ready_tx_empty: assert property (
      transmit_ready_flag |-> host_tx_empty_flag)
      else $error("ready flag while tx words full");
   a_rxff_masked: assert property (masked(irq_rx_full, ctrl_q[14]))
      else $error("rx full request while disabled");
   a_rxne_masked: assert property (
      masked(irq_rx_not_empty, ctrl_q[15]))
      else $error("rx not-empty request while disabled");
   a_txe_masked: assert property (masked(irq_tx_empty, ctrl_q[13]))
      else $error("tx empty request while disabled");
   a_txnf_masked: assert property (
      masked(irq_tx_not_full, ctrl_q[12]))
      else $error("tx not-full request while disabled");
   a_cmd_masked: assert property (masked(irq_host_cmd, ctrl_q[11]))
      else $error("command request while disabled");
   a_nmi_raised: assert property (
      $rose(host_nmi_req) |-> ##[1:8] nmi_host)
      else $error("host nmi not raised");
   a_vector_clears: assert property (
      rd_vec |-> ##2 !(nmi_host || irq_host_cmd))
      else $error("vector read left request pending");
   a_flags_mirror: assert property (
      $changed(ctrl_q[3:0]) |-> ##[0:2] core_to_host_flags == ctrl_q[3:0])
      else $error("core flags not mirrored");
   c_rx_full: cover property (irq_rx_full);
   c_nmi: cover property (nmi_host);
   c_words_held: cover property (!host_tx_empty_flag);
endmodule // host_port_chk

// File: bench/host_model.sv
`timescale 1ns/10ps
// Host processor: fills tx words, empties rx words, raises requests
module host_model (
   // Clock
   input wire logic                   clk,
   // Host pins
   output host_port_pkg::entry_t      host_tx_data,
   output logic                       host_tx_wr,
   output logic                       host_rx_rd,
   output logic [3:0]                 host_to_core_flags,
   output logic                       host_cmd_req,
   output host_port_pkg::cmd_vec_t    host_cmd_vec,
   output logic                       host_nmi_req,
   input  wire host_port_pkg::entry_t host_rx_data,
   input  wire logic                  host_tx_empty_flag,
   input  wire logic                  host_rx_full_flag
);
   import host_port_pkg::*;
   // Pins idle at time zero
   initial begin
      host_tx_data = 64'h0;
      {host_tx_wr, host_rx_rd, host_cmd_req, host_nmi_req} = 4'h0;
      host_to_core_flags = 4'h0;
      host_cmd_vec = 7'h0;
   end
   // Polls a status pin; a flag that never comes is reported
   task automatic wait_flag(input bit rx, output bit ok);
      int n;
      n = 0;
      while ((rx ? host_rx_full_flag : host_tx_empty_flag) !== 1'b1
             && n < 200) begin
         @(posedge clk);
         n++;
      end
      ok = n < 200;
   endtask
   // Long strobe so the synchroniser always sees both edges
   task automatic strobe(input bit rx);
      if (rx)
         host_rx_rd <= 1'b1;
      else
         host_tx_wr <= 1'b1;
      repeat (6) @(posedge clk);
      host_rx_rd <= 1'b0;
      host_tx_wr <= 1'b0;
      repeat (6) @(posedge clk);
      host_tx_data <= ~host_tx_data; // Released bus shows no stale word
   endtask
   task automatic send(input entry_t d, output bit ok);
      wait_flag(1'b0, ok);
      host_tx_data <= d;
      strobe(1'b0);
   endtask
   task automatic fetch(output entry_t d, output bit ok);
      wait_flag(1'b1, ok);
      d = host_rx_data;
      strobe(1'b1);
   endtask
   task automatic request(input bit nmi, input cmd_vec_t v);
      host_cmd_vec <= v;
      host_cmd_req <= !nmi;
      host_nmi_req <= nmi;
      repeat (6) @(posedge clk);
      {host_cmd_req, host_nmi_req} <= 2'b00;
      repeat (6) @(posedge clk);
   endtask
endmodule // host_model

// File: bench/host_port_handshake_status_test.sv
`timescale 1ns/10ps
module host_port_handshake_status_test;
   import host_port_pkg::*;
   localparam int FD = 4;
   logic        clk, rstn, hsel, hwrite;
   logic [31:0] haddr, hwdata, r, r2;
   logic [1:0]  htrans;
   logic [2:0]  hsize = 3'b010;
   logic [3:0]  cf, hf;
   wire         hready, hreadyout, hresp, host_tx_wr, host_rx_rd;
   wire  [31:0] hrdata;
   wire  [3:0]  core_to_host_flags, host_to_core_flags;
   wire         host_tx_empty_flag, host_rx_full_flag, transmit_ready_flag;
   wire         irq_rx_full, irq_rx_not_empty, irq_tx_empty;
   wire         irq_tx_not_full, irq_host_cmd, nmi_host;
   wire         host_cmd_req, host_nmi_req;
   wire entry_t   host_tx_data, host_rx_data;
   wire cmd_vec_t host_cmd_vec;
   entry_t      e, q_in[$], q_out[$];
   cmd_vec_t    v;
   bit          ok;
   int          i, miscompares, comparisons;
   assign hready = hreadyout;
   always #4 clk = ~clk;
   host_port_handshake_status #(.DEPTH(FD)) dut_u (.*);
   host_model host_u (.*);
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
      end
   endtask
   task automatic alive(input bit good);
      if (!good) begin
         miscompares++;
         $display("unexpected at %0t: wait timed out", $time);
         finish_test;
      end
   endtask
   // One single word transfer, waiting out any wait states
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      {hsel, haddr, hwrite, htrans} <= {1'b1, 24'h0, a, w, 2'b10};
      for (n = 0; n < 20 && hready !== 1'b1 || n == 0; n++) @(posedge clk);
      alive(n < 20);
      {htrans, hwdata} <= {2'b00, wd};
      for (n = 0; n < 20 && hready !== 1'b1 || n == 0; n++) @(posedge clk);
      rd = hrdata;
      alive(n < 20);
   endtask
   // Expected status from the queue model
   function automatic logic [63:0] stat_exp();
      int ni, no;
      ni = q_in.size() > FD ? FD : q_in.size();
      no = q_out.size() > 0 ? q_out.size() - 1 : 0;
      return {56'h0, hf, no < FD, no == 0, ni == FD, ni > 0};
   endfunction
   task automatic stat(input string what);
      repeat (4) @(posedge clk);
      bus(8'h04, 1'b0, 32'h0, r);
      check(r, stat_exp(), what);
   endtask
   initial begin
      {clk, rstn, hsel, hwrite, haddr, hwdata, htrans} = '0;
      hf = 4'h0;
      void'($urandom(32'he18d2c4b));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check({host_tx_empty_flag, transmit_ready_flag, hresp},
            3'b110, "rst");
      stat("rst stat");
      bus(8'h1c, 1'b1, 32'hffff, r);
      bus(8'h1c, 1'b0, 32'h0, r);
      check(r, 0, "unmapped");
      // Flags both ways
      for (i = 0; i < 3; i++) begin
         {cf, hf} = 8'($urandom);
         bus(8'h00, 1'b1, {28'h0, cf}, r);
         host_u.host_to_core_flags <= hf;
         repeat (4) @(posedge clk);
         check(core_to_host_flags, cf, "core flags");
         stat("host flags");
      end
      // Host fills the receive side one past its depth
      bus(8'h00, 1'b1, 32'hc000 | cf, r);
      for (i = 0; i <= FD; i++) begin
         e = {$urandom, $urandom};
         host_u.send(e, ok);
         alive(ok);
         q_in.push_back(e);
         stat("fill");
         check(transmit_ready_flag, 0, "ready");
      end
      check(host_tx_empty_flag, 0, "words held");
      check({irq_rx_full, irq_rx_not_empty, irq_tx_empty},
            3'b110, "rx irq");
      while (q_in.size() > 0) begin
         bus(8'h10, 1'b0, 32'h0, r);
         bus(8'h14, 1'b0, 32'h0, r2);
         check({r2, r}, q_in.pop_front(), "rx data");
         stat("drain");
      end
      check({irq_rx_full, irq_rx_not_empty, transmit_ready_flag},
            3'b001, "idle");
      // Core fills the transmit side; the last push is refused
      bus(8'h00, 1'b1, 32'h3000 | cf, r);
      repeat (2) @(posedge clk);
      check({irq_tx_empty, irq_tx_not_full}, 2'b11, "tx irq");
      for (i = 0; i <= FD + 1; i++) begin
         e = {$urandom, $urandom};
         bus(8'h08, 1'b1, e[31:0], r);
         bus(8'h0c, 1'b1, e[63:32], r);
         if (i <= FD)
            q_out.push_back(e);
         stat("push");
      end
      check({host_rx_full_flag, irq_tx_empty, irq_tx_not_full},
            3'b100, "full");
      while (q_out.size() > 0) begin
         host_u.fetch(e, ok);
         alive(ok);
         check(e, q_out.pop_front(), "tx data");
         stat("fetch");
      end
      check({host_rx_full_flag, irq_tx_empty}, 2'b01, "empty");
      // Host command masked, then enabled; vector read clears
      bus(8'h00, 1'b1, {28'h0, cf}, r);
      v = 7'($urandom);
      host_u.request(1'b0, v);
      check(irq_host_cmd, 0, "cmd masked");
      bus(8'h00, 1'b1, 32'h0800 | cf, r);
      repeat (2) @(posedge clk);
      check(irq_host_cmd, 1, "cmd");
      bus(8'h18, 1'b0, 32'h0, r);
      check(r & 32'h37f, {22'h0, 3'b010, v}, "vector");
      host_u.request(1'b1, v);
      check({nmi_host, irq_host_cmd}, 2'b10, "nmi");
      bus(8'h18, 1'b0, 32'h0, r);
      repeat (2) @(posedge clk);
      check({r[9], nmi_host}, 2'b10, "nmi clear");
      finish_test;
   end
endmodule // host_port_handshake_status_test
bind host_port_handshake_status host_port_chk chk_u (.*);
